// ===== ldbce_core.sv
// Functional notes
// - internal samples 28-bit signed 5.23
// - external samples 24-bit 1.23
// - 16 outputs truncated to 24 bits, symmetric clip
// - per-output clip detector, status and event
// - input from any source or instruction result
// - biquad precision 27, 33 or 19 bits
// - run always or on condition; skip holds or passes
// - result flags: zero, sign tests, overflow
// - conditions on input pins (0x01) or output pins (0x02)
// - eight software condition bits
// - modulo-N frame counter wraps to 0
// - 128 instructions, five 32-bit words, 640 per bank
// - word groups follow instruction order
// - biquad words B0 B1 B2 A1 A2, 5.27
// - three banks, one active, switchable live
// - switch at next frame or ramp linearly
// - ramp speed settable; only biquad words ramp
// - zero-state bit clears history on switch
// - 6-bit target point, default 63
// - target only rises in ramp; progress readable
// - ramping banks locked
// - event when progress first equals target
// - program counter restarts each frame
// - processing needs enable and run
module ldbce_core
	import ldbce_pkg::*;
#(
	parameter int N_SRC = 64
)(
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      pclk_en,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [13:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      frame_tick,
	input  wire logic [NUM_PINS-1:0]       mp_pin_level,
	input  wire logic [NUM_PINS*8-1:0]     multipin_function_select,
	input  wire logic [NUM_PINS-1:0]       general_pin_output_value,
	input  wire logic [N_SRC*EXT_W-1:0]    src_samples,
	input  wire logic [7:0]                exec_src_sel,
	input  wire logic                      exec_valid,
	input  wire logic [3:0]                exec_cond_sel,
	input  wire logic [6:0]                exec_cond_arg,
	input  wire logic                      exec_skip_pass,
	input  wire logic [INT_W-1:0]          exec_result,
	input  wire logic                      exec_acc_ovf,
	output logic [6:0]                     exec_instr,
	output logic [INT_W-1:0]               exec_in_sample,
	output logic                           exec_go,
	output logic                           exec_wr,
	output logic [INT_W-1:0]               exec_wr_data,
	input  wire logic                      prm_rd_en,
	input  wire logic [6:0]                prm_rd_instr,
	input  wire logic [2:0]                prm_rd_slot,
	input  wire logic                      prm_rd_biquad,
	input  wire logic [1:0]                prm_rd_prec,
	output logic                           prm_rd_valid,
	output logic [COEF_W-1:0]              prm_rd_data,
	input  wire logic                      out_wr,
	input  wire logic [3:0]                out_idx,
	input  wire logic [INT_W-1:0]          out_data,
	output logic [NUM_OUT*EXT_W-1:0]       out_samples,
	output logic [NUM_OUT-1:0]             clip_event,
	output logic                           engine_active,
	output logic                           clear_state_on_switch,
	output logic                           ramp_reached_irq_source
);

	generate
		if (N_SRC < 1 || N_SRC > 128)
		begin : g_chk
			$error("N_SRC must lie in 1..128");
		end
	endgenerate

	logic [31:0]          pmem [BANK_WORDS*NUM_BANKS];
	logic [INT_W-1:0]     res_mem [NUM_INSTR];
	logic [6:0]           flag_mem [NUM_INSTR];
	logic                 engine_enable_ff;
	logic                 engine_run_ff;
	logic                 ramp_en_ff;
	logic                 zero_ff;
	logic [1:0]           bank_sel_ff;
	logic [7:0]           speed_ff;
	logic [5:0]           target_ff;
	logic [NUM_GCOND-1:0] gcond_ff;
	logic [7:0]           modn_set_ff;
	logic [7:0]           modn_cnt_ff;
	logic [NUM_OUT-1:0]   clip_ff;
	logic [1:0]           cur_bank_ff;
	logic [1:0]           prev_bank_ff;
	logic                 ramp_ff;
	logic                 reached_ff;
	logic [5:0]           progress_ff;
	logic [7:0]           spd_cnt_ff;
	logic [6:0]           pc_ff;
	logic [NUM_PINS-1:0]  mp_meta_ff;
	logic [NUM_PINS-1:0]  mp_sync_ff;
	logic [31:0]          prdata_ff;
	logic                 frame_go;
	logic                 wr_go;
	logic                 is_pmem;
	logic [10:0]          pm_idx;
	logic [1:0]           pm_bank;
	logic                 pm_err;
	logic [31:0]          nxt_rdata;
	logic [NUM_OUT-1:0]   clip_hit;

	function automatic logic [10:0] bank_base(input logic [1:0] b);
		bank_base = (b == 2'd0) ? 11'd0 : (b == 2'd1) ? 11'(BANK_WORDS) : 11'(2 * BANK_WORDS);
	endfunction

	// processing only when both enable and run are set
	assign engine_active = engine_enable_ff & engine_run_ff;
	assign frame_go = pclk_en & frame_tick & engine_active;

	// apb decode; zero wait states whenever the clock is enabled
	assign pready = pclk_en;
	assign prdata = prdata_ff;
	assign wr_go = pclk_en & psel & penable & pwrite & ~pslverr;
	assign is_pmem = (paddr[13] == PMEM_SEL[1]);
	assign pm_idx = paddr[12:2];
	assign pm_bank = (pm_idx < 11'(BANK_WORDS)) ? 2'd0 :
		(pm_idx < 11'(2 * BANK_WORDS)) ? 2'd1 : 2'd2;

	// memory needs enable; writes must stay clear of both ramping banks
	always_comb
	begin
		pm_err = 1'b0;
		if (is_pmem)
		begin
			if (!engine_enable_ff || pm_idx >= 11'(NUM_BANKS * BANK_WORDS))
				pm_err = 1'b1;
			else if (pwrite && ramp_ff && (pm_bank == cur_bank_ff || pm_bank == prev_bank_ff))
				pm_err = 1'b1;
		end
	end

	always_comb
	begin
		pslverr = 1'b0;
		if (psel && penable)
		begin
			if (is_pmem)
				pslverr = pm_err;
			else if (paddr > OFS_CLIP || paddr[1:0] != 2'b00)
				pslverr = 1'b1;
		end
	end

	// read mux, sampled in the setup phase so prdata is a flop
	always_comb
	begin
		nxt_rdata = 32'h0;
		if (is_pmem)
			nxt_rdata = pm_err ? 32'h0 : pmem[pm_idx];
		else
			case (paddr)
				OFS_CTRL: nxt_rdata = {16'h0, speed_ff, 2'b0, bank_sel_ff, zero_ff, ramp_en_ff,
					engine_run_ff, engine_enable_ff};
				OFS_TARGET: nxt_rdata = {26'h0, target_ff};
				OFS_STATUS: nxt_rdata = {21'h0, cur_bank_ff, ramp_ff, 2'b0, progress_ff};
				OFS_GCOND: nxt_rdata = {24'h0, gcond_ff};
				OFS_MODN: nxt_rdata = {24'h0, modn_set_ff};
				OFS_CLIP: nxt_rdata = {16'h0, clip_ff};
				default: nxt_rdata = 32'h0;
			endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= 32'h0;
		else if (pclk_en && psel && !penable && !pwrite)
			prdata_ff <= nxt_rdata;
	end

	// control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			engine_enable_ff <= 1'b0;
			engine_run_ff <= 1'b0;
			ramp_en_ff <= 1'b0;
			zero_ff <= 1'b0;
			bank_sel_ff <= 2'd0;
			speed_ff <= SPEED_RST;
			gcond_ff <= '0;
			modn_set_ff <= MODN_RST;
		end
		else if (wr_go && !is_pmem)
		begin
			if (paddr == OFS_CTRL)
			begin
				engine_enable_ff <= pwdata[CTRL_EN_BIT];
				engine_run_ff <= pwdata[CTRL_RUN_BIT];
				ramp_en_ff <= pwdata[CTRL_RAMP_BIT];
				zero_ff <= pwdata[CTRL_ZERO_BIT];
				// code 3 names no bank and leaves the selection alone
				if (pwdata[CTRL_BANK_LSB +: 2] != 2'd3)
					bank_sel_ff <= pwdata[CTRL_BANK_LSB +: 2];
				speed_ff <= pwdata[CTRL_SPD_LSB +: 8];
			end
			if (paddr == OFS_GCOND)
				gcond_ff <= pwdata[NUM_GCOND-1:0];
			if (paddr == OFS_MODN)
				modn_set_ff <= pwdata[7:0];
		end
	end

	// target point; a lower value is ignored while a ramp runs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			target_ff <= LAMBDA_RST;
		else if (wr_go && paddr == OFS_TARGET && !(ramp_ff && pwdata[5:0] < target_ff))
			target_ff <= pwdata[5:0];
	end

	// parameter memory write port, index = bank*640 + instr*5 + slot
	always_ff @(posedge pclk)
	begin
		if (wr_go && is_pmem)
			pmem[pm_idx] <= pwdata;
	end

	// bank switch and ramp sequencing, once per frame
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cur_bank_ff <= 2'd0;
			prev_bank_ff <= 2'd0;
			ramp_ff <= 1'b0;
			reached_ff <= 1'b0;
			progress_ff <= LAMBDA_END;
			spd_cnt_ff <= 8'h0;
			clear_state_on_switch <= 1'b0;
			ramp_reached_irq_source <= 1'b0;
		end
		else if (pclk_en)
		begin
			clear_state_on_switch <= 1'b0;
			ramp_reached_irq_source <= 1'b0;
			if (frame_go)
			begin
				if (progress_ff != target_ff)
					reached_ff <= 1'b0;
				if (ramp_ff && progress_ff == target_ff && !reached_ff)
				begin
					ramp_reached_irq_source <= 1'b1;
					reached_ff <= 1'b1;
				end
				else if (ramp_ff && progress_ff < target_ff)
				begin
					// a zero speed is served as one frame per step
					if (spd_cnt_ff + 8'h01 >= speed_ff)
					begin
						progress_ff <= progress_ff + 6'h01;
						spd_cnt_ff <= 8'h0;
					end
					else
						spd_cnt_ff <= spd_cnt_ff + 8'h01;
				end
				else if (ramp_ff && progress_ff == LAMBDA_END)
					ramp_ff <= 1'b0;
				// a new selection waits for the running ramp's target
				if ((!ramp_ff || (progress_ff == target_ff && reached_ff))
					&& bank_sel_ff != cur_bank_ff)
				begin
					prev_bank_ff <= cur_bank_ff;
					cur_bank_ff <= bank_sel_ff;
					clear_state_on_switch <= zero_ff;
					spd_cnt_ff <= 8'h0;
					reached_ff <= 1'b0;
					ramp_ff <= ramp_en_ff;
					progress_ff <= ramp_en_ff ? 6'h0 : LAMBDA_END;
				end
			end
		end
	end

	// modulo-N frame counter; N of 0 behaves as 1
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			modn_cnt_ff <= 8'h0;
		else if (frame_go)
			modn_cnt_ff <= (modn_cnt_ff + 8'h01 >= modn_set_ff) ? 8'h0
				: modn_cnt_ff + 8'h01;
	end

	// program counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pc_ff <= 7'h0;
		else if (frame_go)
			pc_ff <= 7'h0;
		else if (pclk_en && exec_valid && engine_active)
			pc_ff <= pc_ff + 7'h01;
	end
	assign exec_instr = pc_ff;

	// pin levels come from outside the clock domain
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mp_meta_ff <= '0;
			mp_sync_ff <= '0;
		end
		else if (pclk_en)
		begin
			mp_meta_ff <= mp_pin_level;
			mp_sync_ff <= mp_meta_ff;
		end
	end

	// execution condition
	always_comb
	begin
		logic [6:0] fl;
		logic [7:0] fsel;
		fl = flag_mem[exec_cond_arg];
		fsel = multipin_function_select[exec_cond_arg[4:0]*8 +: 8];
		case (ldbce_cond_e'(exec_cond_sel))
			COND_ALWAYS: exec_go = 1'b1;
			COND_EQZ: exec_go = fl[0];
			COND_NEZ: exec_go = fl[1];
			COND_GTZ: exec_go = fl[2];
			COND_LTZ: exec_go = fl[3];
			COND_GEZ: exec_go = fl[4];
			COND_LEZ: exec_go = fl[5];
			COND_OVF: exec_go = fl[6];
			COND_PIN_IN: exec_go = (fsel == MP_GPIO_IN) & mp_sync_ff[exec_cond_arg[4:0]];
			COND_PIN_OUT: exec_go = (fsel == MP_GPIO_OUT)
				& general_pin_output_value[exec_cond_arg[4:0]];
			COND_GENERIC: exec_go = gcond_ff[exec_cond_arg[2:0]];
			COND_MODN_ZERO: exec_go = (modn_cnt_ff == 8'h0);
			default: exec_go = 1'b0;
		endcase
	end

	// input source, one cycle ahead of use; 1.23 widens to 5.23
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			exec_in_sample <= '0;
		else if (pclk_en)
		begin
			if (exec_src_sel < 8'(N_SRC))
				exec_in_sample <= {{(INT_W-EXT_W){src_samples[exec_src_sel*EXT_W + EXT_W-1]}},
					src_samples[exec_src_sel*EXT_W +: EXT_W]};
			else
				exec_in_sample <= res_mem[7'(exec_src_sel - 8'(N_SRC))];
		end
	end

	// instruction write-back: result, pass-through or nothing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			exec_wr <= 1'b0;
			exec_wr_data <= '0;
		end
		else if (pclk_en)
		begin
			exec_wr <= exec_valid & engine_active & (exec_go | exec_skip_pass);
			if (exec_valid && engine_active)
				exec_wr_data <= exec_go ? exec_result : exec_in_sample;
		end
	end

	// results and flags kept per instruction for later conditions
	always_ff @(posedge pclk)
	begin
		if (pclk_en && exec_valid && engine_active && exec_go)
		begin
			res_mem[pc_ff] <= exec_result;
			flag_mem[pc_ff] <= {exec_acc_ovf, exec_result[INT_W-1] | ~|exec_result,
				~exec_result[INT_W-1], exec_result[INT_W-1],
				~exec_result[INT_W-1] & |exec_result, |exec_result, ~|exec_result};
		end
	end

	// parameter fetch with biquad interpolation between banks
	always_ff @(posedge pclk or negedge presetn)
	begin
		logic [9:0]         wofs;
		logic signed [31:0] p_old;
		logic signed [31:0] p_new;
		logic [6:0]         w_new;
		logic signed [39:0] mix;
		if (!presetn)
		begin
			prm_rd_valid <= 1'b0;
			prm_rd_data <= '0;
		end
		else if (pclk_en)
		begin
			wofs = 10'(prm_rd_instr * PRM_PER_IN) + 10'(prm_rd_slot);
			p_old = pmem[bank_base(prev_bank_ff) + 11'(wofs)];
			p_new = pmem[bank_base(cur_bank_ff) + 11'(wofs)];
			w_new = {1'b0, progress_ff};
			// other instructions take the new bank at once
			if (ramp_ff && prm_rd_biquad && progress_ff != LAMBDA_END)
				mix = p_old * $signed({1'b0, 7'd64 - w_new}) + p_new * $signed({1'b0, w_new});
			else
				mix = {{2{p_new[31]}}, p_new, 6'h0};
			prm_rd_valid <= prm_rd_en;
			if (prm_rd_en)
				// 5.27 words widened to a 5.54 result
				case (ldbce_prec_e'(prm_rd_prec))
					PREC_DOUBLE: prm_rd_data <= {mix[37:0], 21'h0};
					PREC_REDUCED: prm_rd_data <= {mix[37:14], 35'h0};
					default: prm_rd_data <= {mix[37:6], 27'h0};
				endcase
		end
	end

	// output channels: saturate, then truncate to 24 bits
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUT; gi++)
		begin : g_out
			logic over;
			logic under;
			assign over = ~out_data[INT_W-1] & (out_data[INT_W-2:EXT_W-1] != '0);
			assign under = out_data[INT_W-1] & ((out_data[INT_W-2:EXT_W-1] != '1)
				| (out_data[EXT_W-2:0] == '0));
			assign clip_hit[gi] = out_wr & (out_idx == 4'(gi)) & (over | under);
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					out_samples[gi*EXT_W +: EXT_W] <= '0;
				else if (pclk_en && out_wr && out_idx == 4'(gi))
					out_samples[gi*EXT_W +: EXT_W] <= over ? FS_POS : under ? FS_NEG
						: out_data[EXT_W-1:0];
			end
		end
	endgenerate

	// clip status is sticky; a new clip wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clip_ff <= '0;
			clip_event <= '0;
		end
		else if (pclk_en)
		begin
			clip_event <= clip_hit;
			clip_ff <= (clip_ff & ~((wr_go && paddr == OFS_CLIP) ? pwdata[NUM_OUT-1:0] : '0))
				| clip_hit;
		end
	end

endmodule

// ===== ldbce_pkg.sv
package ldbce_pkg;
	// engine geometry
	localparam int NUM_INSTR  = 128;
	localparam int PRM_PER_IN = 5;
	localparam int NUM_BANKS  = 3;
	localparam int BANK_WORDS = 640;
	localparam int NUM_OUT    = 16;
	localparam int NUM_PINS   = 32;
	localparam int NUM_GCOND  = 8;
	// sample formats: internal 5.23, external 1.23
	localparam int INT_W      = 28;
	localparam int EXT_W      = 24;
	localparam int COEF_W     = 59;
	localparam logic [EXT_W-1:0] FS_POS = 24'h7fffff;
	localparam logic [EXT_W-1:0] FS_NEG = 24'h800001;
	// multipin function codes
	localparam logic [7:0] MP_GPIO_IN  = 8'h01;
	localparam logic [7:0] MP_GPIO_OUT = 8'h02;
	// ramp points
	localparam logic [5:0] LAMBDA_END = 6'h3f;
	localparam logic [5:0] LAMBDA_RST = 6'h3f;
	// register byte offsets
	localparam logic [13:0] OFS_CTRL   = 14'h0000;
	localparam logic [13:0] OFS_TARGET = 14'h0004;
	localparam logic [13:0] OFS_STATUS = 14'h0008;
	localparam logic [13:0] OFS_GCOND  = 14'h000c;
	localparam logic [13:0] OFS_MODN   = 14'h0010;
	localparam logic [13:0] OFS_CLIP   = 14'h0014;
	localparam logic [1:0]  PMEM_SEL   = 2'h2;
	// control and status field positions
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_RUN_BIT  = 1;
	localparam int CTRL_RAMP_BIT = 2;
	localparam int CTRL_ZERO_BIT = 3;
	localparam int CTRL_BANK_LSB = 4;
	localparam int CTRL_SPD_LSB  = 8;
	localparam int STAT_RAMP_BIT = 8;
	localparam int STAT_BANK_LSB = 9;
	// reset values
	localparam logic [7:0] SPEED_RST = 8'h01;
	localparam logic [7:0] MODN_RST  = 8'h01;
	// condition selector and coefficient precision
	typedef enum logic [3:0] {
		COND_ALWAYS, COND_EQZ, COND_NEZ, COND_GTZ, COND_LTZ, COND_GEZ, COND_LEZ,
		COND_OVF, COND_PIN_IN, COND_PIN_OUT, COND_GENERIC, COND_MODN_ZERO
	} ldbce_cond_e;
	typedef enum logic [1:0] {PREC_SINGLE, PREC_DOUBLE, PREC_REDUCED} ldbce_prec_e;
endpackage

// ===== ldbce_checker.sv
module ldbce_checker
	import ldbce_pkg::*;
(
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire logic                     pclk_en,
	input wire logic                     frame_tick,
	input wire logic                     exec_valid,
	input wire logic [3:0]               exec_cond_sel,
	input wire logic                     exec_skip_pass,
	input wire logic [INT_W-1:0]         exec_result,
	input wire logic [6:0]               exec_instr,
	input wire logic [INT_W-1:0]         exec_in_sample,
	input wire logic                     exec_go,
	input wire logic                     exec_wr,
	input wire logic [INT_W-1:0]         exec_wr_data,
	input wire logic                     out_wr,
	input wire logic [3:0]               out_idx,
	input wire logic [INT_W-1:0]         out_data,
	input wire logic [NUM_OUT*EXT_W-1:0] out_samples,
	input wire logic [NUM_OUT-1:0]       clip_event,
	input wire logic                     engine_active,
	input wire logic                     clear_state_on_switch,
	input wire logic                     ramp_reached_irq_source
);
	logic             take;
	logic [3:0]       idx_ff;
	logic [EXT_W-1:0] dat_ff;

	// an instruction is accepted this cycle
	assign take = pclk_en && exec_valid && engine_active;

	// output index and data, one cycle late, written or not
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idx_ff <= '0;
			dat_ff <= '0;
		end
		else if (pclk_en)
		begin
			idx_ff <= out_idx;
			dat_ff <= out_data[EXT_W-1:0];
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_clip_pos;
		pclk_en && out_wr && $signed(out_data) > 28'sh07fffff
		|=> out_samples[idx_ff*EXT_W +: EXT_W] == FS_POS && clip_event[idx_ff];
	endproperty
	a_clip_pos: assert property (p_clip_pos) else $error("positive clip wrong");
	property p_clip_neg;
		pclk_en && out_wr && $signed(out_data) < -28'sh07fffff
		|=> out_samples[idx_ff*EXT_W +: EXT_W] == FS_NEG && clip_event[idx_ff];
	endproperty
	a_clip_neg: assert property (p_clip_neg) else $error("negative clip wrong");
	// in range: plain truncation to 24 bits and no clip flag
	property p_trunc;
		pclk_en && out_wr && $signed(out_data) <= 28'sh07fffff && $signed(out_data) >= -28'sh07fffff
		|=> out_samples[idx_ff*EXT_W +: EXT_W] == dat_ff && !clip_event[idx_ff];
	endproperty
	a_trunc: assert property (p_trunc) else $error("output truncation wrong");
	property p_run;
		take && exec_go |=> exec_wr && exec_wr_data == $past(exec_result);
	endproperty
	a_run: assert property (p_run) else $error("executed result not written");
	property p_hold;
		take && !exec_go && !exec_skip_pass |=> !exec_wr;
	endproperty
	a_hold: assert property (p_hold) else $error("skipped output not held");
	property p_pass;
		take && !exec_go && exec_skip_pass |=> exec_wr && exec_wr_data == $past(exec_in_sample);
	endproperty
	a_pass: assert property (p_pass) else $error("skipped input not passed");
	property p_idle;
		pclk_en && exec_valid && !engine_active |=> !exec_wr;
	endproperty
	a_idle: assert property (p_idle) else $error("execution while stopped");
	property p_always;
		exec_cond_sel == COND_ALWAYS |-> exec_go;
	endproperty
	a_always: assert property (p_always) else $error("always condition false");
	property p_pc0;
		pclk_en && frame_tick && engine_active |=> exec_instr == 7'h00;
	endproperty
	a_pc0: assert property (p_pc0) else $error("counter not restarted");
	property p_pcinc;
		take && !frame_tick |=> exec_instr == $past(exec_instr) + 7'h01;
	endproperty
	a_pcinc: assert property (p_pcinc) else $error("counter not advanced");
	property p_irq;
		ramp_reached_irq_source |=> !ramp_reached_irq_source;
	endproperty
	a_irq: assert property (p_irq) else $error("ramp event too long");
	property p_zclr;
		clear_state_on_switch |=> !clear_state_on_switch [*2];
	endproperty
	a_zclr: assert property (p_zclr) else $error("state clear too long");

	c_clip: cover property (pclk_en && out_wr && $signed(out_data) > 28'sh07fffff);
	c_irq: cover property (ramp_reached_irq_source);
	c_pass: cover property (take && !exec_go && exec_skip_pass);
endmodule

bind ldbce_core ldbce_checker u_chk (.*);

// ===== ldbce_partner.sv
module ldbce_partner
	import ldbce_pkg::*;
#(
	parameter int N_SRC = 64
)(
	input  wire logic [NUM_PINS-1:0]    pin_drv,
	output logic      [N_SRC*EXT_W-1:0] src_samples,
	output logic      [NUM_PINS-1:0]    mp_pin_level
);
	// fixed 1.23 words; channel 0 negative so sign extension shows
	always_comb
	begin
		for (int k = 0; k < N_SRC; k++)
			src_samples[k*EXT_W +: EXT_W] = (k == 0) ? 24'h800010 : 24'(k * 24'h010203);
	end

	// pins as ideal drivers; the core does its own synchronising
	assign mp_pin_level = pin_drv;
endmodule

// ===== testbench.sv
module testbench
	import ldbce_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic                     frame_tick, exec_valid, exec_skip_pass, exec_acc_ovf, exec_go;
	logic                     exec_wr, prm_rd_en, prm_rd_biquad, prm_rd_valid, out_wr;
	logic                     engine_active, clear_state_on_switch, ramp_reached_irq_source;
	logic [13:0]              paddr;
	logic [31:0]              pwdata, prdata, rd;
	logic [NUM_PINS-1:0]      pin_drv, mp_pin_level, general_pin_output_value;
	logic [NUM_PINS*8-1:0]    multipin_function_select;
	logic [64*EXT_W-1:0]      src_samples;
	logic [7:0]               exec_src_sel;
	logic [3:0]               exec_cond_sel, out_idx;
	logic [6:0]               exec_cond_arg, exec_instr, prm_rd_instr;
	logic [INT_W-1:0]         exec_result, exec_in_sample, exec_wr_data, out_data;
	logic [2:0]               prm_rd_slot;
	logic [1:0]               prm_rd_prec;
	logic [COEF_W-1:0]        prm_rd_data;
	logic [NUM_OUT*EXT_W-1:0] out_samples;
	logic [NUM_OUT-1:0]       clip_event;
	int                       fail_count, compares, irq_n, zclr_n, n;

	ldbce_partner #(.N_SRC(64)) u_far (.pin_drv, .src_samples, .mp_pin_level);
	ldbce_core #(.N_SRC(64)) dut (.*, .pclk_en(1'b1));

	initial
	begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end

	// pulse counters; events are one cycle wide
	always @(posedge pclk)
	begin
		irq_n <= irq_n + (ramp_reached_irq_source === 1'b1);
		zclr_n <= zclr_n + (clear_state_on_switch === 1'b1);
	end

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic rchk(input string nm, input logic [13:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	task automatic frame();
		@(posedge pclk);
		frame_tick <= 1;
		@(posedge pclk);
		frame_tick <= 0;
		repeat (3) @(posedge pclk);
	endtask

	// one instruction slot: condition, skip mode and result
	task automatic ex(input logic [3:0] c, input logic [6:0] a, input logic p, input logic [27:0] r);
		@(posedge pclk);
		exec_valid <= 1;
		exec_cond_sel <= c;
		exec_cond_arg <= a;
		exec_skip_pass <= p;
		exec_result <= r;
		@(posedge pclk);
		exec_valid <= 0;
		@(negedge pclk);
	endtask

	task automatic t_reset();
		rchk("ctrl", OFS_CTRL, 32'h00000100);
		rchk("target", OFS_TARGET, 32'h0000003f);
		rchk("status", OFS_STATUS, 32'h0000003f);
		rchk("modn", OFS_MODN, 32'h00000001);
		apb(0, 14'h0018, 32'h0);
		chk("unmapped", 1, err);
	endtask

	task automatic t_param();
		apb(1, OFS_CTRL, 32'h00000101);
		@(negedge pclk);
		chk("idle", 0, engine_active);
		apb(1, 14'h2034, 32'h08000000);
		rchk("param", 14'h2034, 32'h08000000);
		apb(1, 14'h3e00, 32'h00000001);
		chk("past end", 1, err);
		apb(1, OFS_CTRL, 32'h00000103);
		@(negedge pclk);
		chk("active", 1, engine_active);
		@(posedge pclk);
		prm_rd_en <= 1;
		prm_rd_instr <= 7'h02;
		prm_rd_slot <= 3'h3;
		prm_rd_biquad <= 1;
		prm_rd_prec <= PREC_SINGLE;
		@(posedge pclk);
		prm_rd_en <= 0;
		@(negedge pclk);
		chk("prm valid", 1, prm_rd_valid);
		chk("prm data", {32'h08000000, 27'h0}, prm_rd_data);
	endtask

	task automatic t_clip();
		logic [INT_W-1:0] v [3] = '{28'h0800000, 28'hf7ffffe, 28'h0123456};
		logic [EXT_W-1:0] e [3] = '{FS_POS, FS_NEG, 24'h123456};
		for (int i = 0; i < 3; i++)
		begin
			@(posedge pclk);
			out_wr <= 1;
			out_idx <= 4'(i + 5);
			out_data <= v[i];
			@(posedge pclk);
			out_wr <= 0;
			@(negedge pclk);
			chk("out", e[i], out_samples[(i+5)*EXT_W +: EXT_W]);
			chk("clip event", i < 2, clip_event[i+5]);
		end
		rchk("clip sticky", OFS_CLIP, 32'h00000060);
		apb(1, OFS_CLIP, 32'h0000ffff);
		rchk("clip clear", OFS_CLIP, 32'h00000000);
	endtask

	task automatic t_cond();
		logic [11:0] t [10] = '{{COND_EQZ, 7'd0, 1'b1}, {COND_NEZ, 7'd0, 1'b0},
			{COND_GTZ, 7'd0, 1'b0}, {COND_LTZ, 7'd0, 1'b0}, {COND_GEZ, 7'd0, 1'b1},
			{COND_LEZ, 7'd0, 1'b1}, {COND_OVF, 7'd0, 1'b1}, {COND_GENERIC, 7'd1, 1'b0},
			{COND_PIN_IN, 7'd3, 1'b1}, {COND_PIN_OUT, 7'd4, 1'b1}};
		apb(1, OFS_GCOND, 32'h00000001);
		pin_drv <= 32'h00000008;
		multipin_function_select <= 256'h0201000000;
		general_pin_output_value <= 32'h00000010;
		frame();
		exec_acc_ovf <= 1;
		ex(COND_ALWAYS, 7'd0, 1'b0, 28'h0);
		exec_acc_ovf <= 0;
		for (int i = 0; i < 10; i++)
		begin
			@(posedge pclk);
			exec_cond_sel <= t[i][11:8];
			exec_cond_arg <= t[i][7:1];
			@(negedge pclk);
			chk("go", t[i][0], exec_go);
		end
		ex(COND_GENERIC, 7'd0, 1'b0, 28'h0000123);
		chk("generic run", 28'h0000123, exec_wr_data);
		ex(COND_GENERIC, 7'd1, 1'b0, 28'h0);
		chk("hold", 0, exec_wr);
		ex(COND_GENERIC, 7'd1, 1'b1, 28'h0);
		chk("pass", 28'hf800010, exec_wr_data);
	endtask

	task automatic t_modn();
		logic [5:0] g;
		apb(1, OFS_MODN, 32'h00000003);
		exec_cond_sel <= COND_MODN_ZERO;
		for (int i = 0; i < 6; i++)
		begin
			frame();
			@(negedge pclk);
			g[i] = exec_go;
		end
		chk("modn hits", 2, $countones(g));
		chk("modn period", g[2:0], g[5:3]);
	endtask

	task automatic t_bank();
		apb(1, OFS_CTRL, 32'h0000011b);
		n = zclr_n;
		frame();
		chk("state clear", n + 1, zclr_n);
		rchk("bank 1", OFS_STATUS, 32'h0000023f);
	endtask

	task automatic t_ramp();
		apb(1, OFS_TARGET, 32'h0000001f);
		apb(1, OFS_CTRL, 32'h00000127);
		n = irq_n;
		for (int i = 0; i < 80 && irq_n == n; i++)
			frame();
		chk("ramp event", n + 1, irq_n);
		apb(0, OFS_STATUS, 32'h0);
		chk("paused", 9'h11f, rd[8:0]);
		apb(1, 14'h3400, 32'h00000001);
		chk("dest locked", 1, err);
		apb(1, 14'h2a00, 32'h00000001);
		chk("src locked", 1, err);
		apb(1, 14'h2000, 32'h00000001);
		chk("other open", 0, err);
		apb(1, OFS_TARGET, 32'h0000000a);
		rchk("no lower", OFS_TARGET, 32'h0000001f);
		apb(1, OFS_TARGET, 32'h0000003f);
		rd = 32'h100;
		for (int i = 0; i < 80 && rd[8]; i++)
		begin
			frame();
			apb(0, OFS_STATUS, 32'h0);
		end
		chk("ramp done", 32'h0000043f, rd);
	endtask

	task automatic finish_test();
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		{presetn, psel, penable, pwrite, frame_tick, exec_valid, exec_skip_pass} = '0;
		{exec_acc_ovf, prm_rd_en, prm_rd_biquad, out_wr, paddr, pwdata, pin_drv} = '0;
		{multipin_function_select, general_pin_output_value, exec_src_sel} = '0;
		{exec_cond_sel, out_idx, exec_cond_arg, prm_rd_instr, exec_result, out_data} = '0;
		{prm_rd_slot, prm_rd_prec, fail_count, compares, irq_n, zclr_n} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1;
		t_reset();
		t_param();
		t_clip();
		t_cond();
		t_modn();
		t_bank();
		t_ramp();
		finish_test();
	end

	// hang guard, well past the longest ramp
	initial
	begin
		#2000000;
		fail_count++;
		finish_test();
	end
endmodule
